// file: verilog/ebt_pkg.sv
// constants, field layout and modes of the two-channel 8-bit timer control
package ebt_pkg;
	// ****************************************
	// register port map
	// ****************************************
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] OFF_CTRL_CH0 = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_CTRL_CH1 = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_STAT_CH0 = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_STAT_CH1 = 3'h3;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STAT_CH0_RST = 8'h00;
	localparam logic [7:0] STAT_CH1_RST = 8'h10;
	localparam logic [7:0] READ_ZERO = 8'h00;
	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_MATCH_B_IE = 7;
	localparam int CTRL_MATCH_A_IE = 6;
	localparam int CTRL_WRAP_IE = 5;
	localparam int CTRL_CLR_HI = 4;
	localparam int CTRL_CLR_LO = 3;
	localparam int CTRL_CKS_HI = 2;
	localparam int STAT_MATCH_B = 7;
	localparam int STAT_MATCH_A = 6;
	localparam int STAT_WRAP = 5;
	localparam int STAT_TRIG = 4;
	localparam int STAT_ACT_B_LO = 2;
	localparam int STAT_ACT_A_LO = 0;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] COUNT_ZERO = 8'h00;
	// ****************************************
	// prescaler taps
	// ****************************************
	localparam int PRE_W = 13;
	localparam logic [PRE_W-1:0] TAP_DIV8 = 13'h0007;
	localparam logic [PRE_W-1:0] TAP_DIV64 = 13'h003f;
	localparam logic [PRE_W-1:0] TAP_DIV8192 = 13'h1fff;
	localparam logic [PRE_W-1:0] PRE_STEP = 13'h0001;
	// ****************************************
	// modes
	// ****************************************
	typedef enum logic [2:0] {
		CKS_OFF = 3'h0,
		CKS_DIV8 = 3'h1,
		CKS_DIV64 = 3'h2,
		CKS_DIV8192 = 3'h3,
		CKS_CASCADE = 3'h4,
		CKS_EXT_RISE = 3'h5,
		CKS_EXT_FALL = 3'h6,
		CKS_EXT_BOTH = 3'h7
	} ebt_cks_e;
	typedef enum logic [1:0] {
		CLR_NONE = 2'h0,
		CLR_MATCH_A = 2'h1,
		CLR_MATCH_B = 2'h2,
		CLR_EXT = 2'h3
	} ebt_clr_e;
	typedef enum logic [1:0] {
		ACT_KEEP = 2'h0,
		ACT_LOW = 2'h1,
		ACT_HIGH = 2'h2,
		ACT_TOGGLE = 2'h3
	} ebt_act_e;
endpackage : ebt_pkg

// file: verilog/ebt_timer.sv
// two-channel 8-bit timer: control, status flags, count sources and outputs
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
// ****************************************
// ****************************************
module ebt_timer
	import ebt_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hw_standby,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] compare_value_a_ch0,
	input wire logic [7:0] compare_value_b_ch0,
	input wire logic [7:0] compare_value_a_ch1,
	input wire logic [7:0] compare_value_b_ch1,
	input wire logic [1:0] ext_clk_in,
	input wire logic [1:0] ext_reset_in,
	input wire logic [1:0] dtc_service_a,
	input wire logic [1:0] dtc_service_b,
	input wire logic [1:0] irq_disable_select_a,
	input wire logic [1:0] irq_disable_select_b,
	output logic [7:0] count_value_ch0,
	output logic [7:0] count_value_ch1,
	output logic [1:0] match_a_irq,
	output logic [1:0] match_b_irq,
	output logic [1:0] wrap_irq,
	output logic [1:0] timer_out,
	output logic [1:0] timer_out_en,
	output logic conversion_start
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic tap_end(input logic [PRE_W-1:0] pre, input logic [PRE_W-1:0] mask);
		return (pre & mask) == mask;
	endfunction : tap_end

	function automatic logic out_next(input logic [1:0] act_a, input logic hit_a,
		input logic [1:0] act_b, input logic hit_b, input logic cur);
		logic [1:0] ea;
		logic [1:0] eb;
		ea = hit_a ? act_a : ACT_KEEP;
		eb = hit_b ? act_b : ACT_KEEP;
		if (ea == ACT_TOGGLE || eb == ACT_TOGGLE) begin
			return ~cur;
		end else if (ea == ACT_HIGH || eb == ACT_HIGH) begin
			return 1'b1;
		end else if (ea == ACT_LOW || eb == ACT_LOW) begin
			return 1'b0;
		end
		return cur;
	endfunction : out_next

	// ****************************************
	// state
	// ****************************************
	logic [7:0] timer_ctrl [2];
	logic [7:0] cnt [2];
	logic [7:0] cmp_a [2];
	logic [7:0] cmp_b [2];
	logic [1:0] flag_a;
	logic [1:0] flag_b;
	logic [1:0] flag_w;
	logic [1:0] armed_a;
	logic [1:0] armed_b;
	logic [1:0] armed_w;
	logic trig_en;
	logic [3:0] out_act [2];
	logic [PRE_W-1:0] pre;
	logic [1:0] ext_clk_q;
	logic [1:0] ext_rst_q;
	logic tick8;
	logic tick64;
	logic tick8192;
	logic [1:0] base_pulse;
	logic [1:0] pulse;
	logic [1:0] eq_a;
	logic [1:0] eq_b;
	logic [1:0] clr_cond;
	logic [1:0] ext_clr;
	logic [1:0] match_a;
	logic [1:0] match_b;
	logic [1:0] wrap;
	logic [1:0] wr_stat;
	logic [1:0] clr_a;
	logic [1:0] clr_b;
	logic [1:0] clr_w;
	ebt_cks_e cks [2];
	ebt_clr_e clr_sel [2];

	assign cmp_a[0] = compare_value_a_ch0;
	assign cmp_b[0] = compare_value_b_ch0;
	assign cmp_a[1] = compare_value_a_ch1;
	assign cmp_b[1] = compare_value_b_ch1;
	assign count_value_ch0 = cnt[0];
	assign count_value_ch1 = cnt[1];
	assign wr_stat[0] = reg_wr && reg_addr == OFF_STAT_CH0;
	assign wr_stat[1] = reg_wr && reg_addr == OFF_STAT_CH1;

	// ****************************************
	// control registers
	// ****************************************
	// reset and standby clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_ctrl[0] <= CTRL_RST;
			timer_ctrl[1] <= CTRL_RST;
		end else if (hw_standby) begin
			timer_ctrl[0] <= CTRL_RST;
			timer_ctrl[1] <= CTRL_RST;
		end else if (reg_wr && reg_addr == OFF_CTRL_CH0) begin
			timer_ctrl[0] <= reg_wdata;
		end else if (reg_wr && reg_addr == OFF_CTRL_CH1) begin
			timer_ctrl[1] <= reg_wdata;
		end
	end

	always_comb begin
		for (int ch = 0; ch < 2; ch++) begin
			cks[ch] = ebt_cks_e'(timer_ctrl[ch][CTRL_CKS_HI:0]);
			clr_sel[ch] = ebt_clr_e'(timer_ctrl[ch][CTRL_CLR_HI:CTRL_CLR_LO]);
		end
	end

	// ****************************************
	// count sources
	// ****************************************
	// free-running divider; each tap ends on the tap's falling edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre <= '0;
		end else begin
			pre <= pre + PRE_STEP;
		end
	end

	assign tick8 = tap_end(pre, TAP_DIV8);
	assign tick64 = tap_end(pre, TAP_DIV64);
	assign tick8192 = tap_end(pre, TAP_DIV8192);

	// pins are synchronous; one stage only for edge detection
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_clk_q <= '0;
			ext_rst_q <= '0;
		end else begin
			ext_clk_q <= ext_clk_in;
			ext_rst_q <= ext_reset_in;
		end
	end

	always_comb begin
		for (int ch = 0; ch < 2; ch++) begin
			eq_a[ch] = cnt[ch] == cmp_a[ch];
			eq_b[ch] = cnt[ch] == cmp_b[ch];
			clr_cond[ch] = (clr_sel[ch] == CLR_MATCH_A && eq_a[ch]) ||
				(clr_sel[ch] == CLR_MATCH_B && eq_b[ch]);
			ext_clr[ch] = clr_sel[ch] == CLR_EXT && ext_reset_in[ch] && !ext_rst_q[ch];
			unique case (cks[ch])
				CKS_OFF: base_pulse[ch] = 1'b0;
				CKS_DIV8: base_pulse[ch] = tick8;
				CKS_DIV64: base_pulse[ch] = tick64;
				CKS_DIV8192: base_pulse[ch] = tick8192;
				CKS_CASCADE: base_pulse[ch] = 1'b0;
				CKS_EXT_RISE: base_pulse[ch] = ext_clk_in[ch] && !ext_clk_q[ch];
				CKS_EXT_FALL: base_pulse[ch] = !ext_clk_in[ch] && ext_clk_q[ch];
				CKS_EXT_BOTH: base_pulse[ch] = ext_clk_in[ch] != ext_clk_q[ch];
			endcase
		end
		// cascade; both set gives no pulse, and no loop
		pulse[0] = base_pulse[0];
		pulse[1] = base_pulse[1];
		if (cks[0] == CKS_CASCADE) begin
			pulse[0] = cks[1] != CKS_CASCADE && base_pulse[1] &&
				cnt[1] == COUNT_MAX && !clr_cond[1];
		end
		if (cks[1] == CKS_CASCADE) begin
			pulse[1] = cks[0] != CKS_CASCADE && base_pulse[0] && eq_a[0];
		end
		for (int ch = 0; ch < 2; ch++) begin
			// match taken at the count pulse ending equality
			match_a[ch] = pulse[ch] && eq_a[ch];
			match_b[ch] = pulse[ch] && eq_b[ch];
			wrap[ch] = pulse[ch] && cnt[ch] == COUNT_MAX && !clr_cond[ch];
		end
	end

	// ****************************************
	// counters
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt[0] <= COUNT_ZERO;
			cnt[1] <= COUNT_ZERO;
		end else begin
			for (int ch = 0; ch < 2; ch++) begin
				if (hw_standby || ext_clr[ch]) begin
					cnt[ch] <= COUNT_ZERO;
				end else if (pulse[ch]) begin
					cnt[ch] <= clr_cond[ch] ? COUNT_ZERO : cnt[ch] + 8'h01;
				end
			end
		end
	end

	// ****************************************
	// status flags
	// ****************************************
	always_comb begin
		for (int ch = 0; ch < 2; ch++) begin
			// only zero after a read of one clears, or for a and b a dtc service with its disable select low
			clr_a[ch] = wr_stat[ch] && armed_a[ch] && !reg_wdata[STAT_MATCH_A];
			clr_b[ch] = wr_stat[ch] && armed_b[ch] && !reg_wdata[STAT_MATCH_B];
			clr_w[ch] = wr_stat[ch] && armed_w[ch] && !reg_wdata[STAT_WRAP];
			clr_a[ch] = clr_a[ch] || (dtc_service_a[ch] && !irq_disable_select_a[ch]);
			clr_b[ch] = clr_b[ch] || (dtc_service_b[ch] && !irq_disable_select_b[ch]);
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_a <= '0;
			flag_b <= '0;
			flag_w <= '0;
		end else if (hw_standby) begin
			flag_a <= '0;
			flag_b <= '0;
			flag_w <= '0;
		end else begin
			flag_a <= match_a | (flag_a & ~clr_a);
			flag_b <= match_b | (flag_b & ~clr_b);
			flag_w <= wrap | (flag_w & ~clr_w);
		end
	end

	// read arms the clear; a write to the same channel's status disarms it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_a <= '0;
			armed_b <= '0;
			armed_w <= '0;
		end else begin
			for (int ch = 0; ch < 2; ch++) begin
				if (hw_standby || wr_stat[ch]) begin
					armed_a[ch] <= 1'b0;
					armed_b[ch] <= 1'b0;
					armed_w[ch] <= 1'b0;
				end else if (reg_rd && reg_addr == (ch == 0 ? OFF_STAT_CH0 : OFF_STAT_CH1)) begin
					armed_a[ch] <= flag_a[ch];
					armed_b[ch] <= flag_b[ch];
					armed_w[ch] <= flag_w[ch];
				end
			end
		end
	end

	// ****************************************
	// status control bits
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_en <= STAT_CH0_RST[STAT_TRIG];
			out_act[0] <= STAT_CH0_RST[3:0];
			out_act[1] <= STAT_CH1_RST[3:0];
		end else if (hw_standby) begin
			trig_en <= STAT_CH0_RST[STAT_TRIG];
			out_act[0] <= STAT_CH0_RST[3:0];
			out_act[1] <= STAT_CH1_RST[3:0];
		end else begin
			if (wr_stat[0]) begin
				trig_en <= reg_wdata[STAT_TRIG];
				out_act[0] <= reg_wdata[3:0];
			end
			if (wr_stat[1]) begin
				out_act[1] <= reg_wdata[3:0];
			end
		end
	end

	// ****************************************
	// register read port
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= READ_ZERO;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFF_CTRL_CH0: reg_rdata <= timer_ctrl[0];
				OFF_CTRL_CH1: reg_rdata <= timer_ctrl[1];
				OFF_STAT_CH0: reg_rdata <= {flag_b[0], flag_a[0], flag_w[0], trig_en, out_act[0]};
				OFF_STAT_CH1: reg_rdata <= {flag_b[1], flag_a[1], flag_w[1],
					STAT_CH1_RST[STAT_TRIG], out_act[1]};
				default: reg_rdata <= READ_ZERO;
			endcase
		end else begin
			reg_rdata <= READ_ZERO;
		end
	end

	// ****************************************
	// requests and outputs
	// ****************************************
	// enable gating; held while the flag stands
	always_comb begin
		for (int ch = 0; ch < 2; ch++) begin
			match_a_irq[ch] = flag_a[ch] && timer_ctrl[ch][CTRL_MATCH_A_IE];
			match_b_irq[ch] = flag_b[ch] && timer_ctrl[ch][CTRL_MATCH_B_IE];
			wrap_irq[ch] = flag_w[ch] && timer_ctrl[ch][CTRL_WRAP_IE];
			// output disabled with no action selected
			timer_out_en[ch] = |out_act[ch];
		end
	end

	// output low from reset until a match acts
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_out <= '0;
		end else if (hw_standby) begin
			timer_out <= '0;
		end else begin
			for (int ch = 0; ch < 2; ch++) begin
				timer_out[ch] <= out_next(out_act[ch][STAT_ACT_A_LO +: 2], match_a[ch],
					out_act[ch][STAT_ACT_B_LO +: 2], match_b[ch], timer_out[ch]);
			end
		end
	end

	// one-cycle request as channel 0 match-a sets the flag, while trig_en is set
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			conversion_start <= 1'b0;
		end else begin
			conversion_start <= match_a[0] && trig_en && !hw_standby;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_stat0_rd_one;
		reg_rd && reg_addr == OFF_STAT_CH0 && flag_w[0] && !hw_standby;
	endsequence
	sequence s_stat0_wr_zero;
		reg_wr && reg_addr == OFF_STAT_CH0 && !reg_wdata[STAT_WRAP] && !wrap[0];
	endsequence

	ctrl_standby_clr_a: assert property (hw_standby |=> timer_ctrl[0] == CTRL_RST && timer_ctrl[1] == CTRL_RST) else $error("ctrl not cleared by standby");
	wrap_gate_a: assert property (!timer_ctrl[0][CTRL_WRAP_IE] |-> !wrap_irq[0]) else $error("wrap request not gated");
	match_clear_a: assert property (match_a[0] && clr_sel[0] == CLR_MATCH_A && !hw_standby |=> cnt[0] == COUNT_ZERO) else $error("counter not cleared on match a");
	div8_rate_a: assert property (tick8 |=> (!tick8) [*7] ##1 tick8) else $error("divide by 8 tap wrong");
	cascade_stop_a: assert property (cks[0] == CKS_CASCADE && cks[1] == CKS_CASCADE |-> pulse == 2'b00) else $error("double cascade counted");
	ext_rise_a: assert property (cks[1] == CKS_EXT_RISE && $rose(ext_clk_in[1]) |-> pulse[1]) else $error("rising edge missed");
	flag_b_set_a: assert property (match_b[1] && !hw_standby |=> flag_b[1]) else $error("match b flag not set");
	flag_keep_a: assert property (flag_a[0] && wr_stat[0] && reg_wdata[STAT_MATCH_A] && !dtc_service_a[0] && !hw_standby |=> flag_a[0]) else $error("write of one cleared flag");
	read_clear_a: assert property (s_stat0_rd_one ##1 s_stat0_wr_zero |=> !flag_w[0]) else $error("read then zero did not clear");
	wrap_set_a: assert property (wrap[0] && !hw_standby && !ext_clr[0] |=> flag_w[0] && cnt[0] == COUNT_ZERO) else $error("wrap not flagged");
	conv_req_a: assert property (match_a[0] && trig_en && !hw_standby |=> conversion_start && flag_a[0]) else $error("conversion request missing");
	reserved_one_a: assert property (reg_rd && reg_addr == OFF_STAT_CH1 |=> reg_rdata[STAT_TRIG]) else $error("reserved bit not one");
	toggle_prio_a: assert property (match_a[1] && match_b[1] && out_act[1][3:2] == ACT_TOGGLE && !hw_standby |=> timer_out[1] != $past(timer_out[1])) else $error("toggle lost priority");
endmodule : ebt_timer

// file: sim/tb.sv
// self-checking testbench of the two-channel 8-bit timer control
`timescale 1ns/1ps
module tb import ebt_pkg::*;;
	logic core_clk, rst_n, hw_standby, reg_wr, reg_rd, conversion_start;
	logic [ADDR_W-1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rdv, count_value_ch0, count_value_ch1;
	logic [7:0] cmp_a0, cmp_b0, cmp_a1, cmp_b1;
	logic [1:0] ext_clk_in, ext_reset_in, dtc_service_a, dtc_service_b;
	logic [1:0] irq_disable_select_a, irq_disable_select_b;
	logic [1:0] match_a_irq, match_b_irq, wrap_irq, timer_out, timer_out_en;
	int miscompares = 0;
	int comparisons = 0;
	int conv_cnt = 0;

	ebt_timer DUT (.core_clk(core_clk), .rst_n(rst_n), .hw_standby(hw_standby),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .compare_value_a_ch0(cmp_a0), .compare_value_b_ch0(cmp_b0),
		.compare_value_a_ch1(cmp_a1), .compare_value_b_ch1(cmp_b1), .ext_clk_in(ext_clk_in),
		.ext_reset_in(ext_reset_in), .dtc_service_a(dtc_service_a),
		.dtc_service_b(dtc_service_b), .irq_disable_select_a(irq_disable_select_a),
		.irq_disable_select_b(irq_disable_select_b), .count_value_ch0(count_value_ch0),
		.count_value_ch1(count_value_ch1), .match_a_irq(match_a_irq),
		.match_b_irq(match_b_irq), .wrap_irq(wrap_irq), .timer_out(timer_out),
		.timer_out_en(timer_out_en), .conversion_start(conversion_start));

	// ****************************************
	// clock, pulse monitor, watchdog
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// the request is a single-cycle pulse, so it is counted rather than sampled
	always @(posedge core_clk) begin
		if (conversion_start === 1'b1) conv_cnt++;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		final_report();
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rdv = reg_rdata;
		check(what, rdv, exp);
	endtask : rd
	// each call level-toggles the external clock; edges are four cycles apart
	task automatic ext_edges(input int ch, input int n);
		repeat (n) begin
			@(posedge core_clk);
			ext_clk_in[ch] <= ~ext_clk_in[ch];
			repeat (3) @(posedge core_clk);
		end
		#1;
	endtask : ext_edges
	task automatic dtc_a0();
		@(posedge core_clk);
		dtc_service_a[0] <= 1'b1;
		@(posedge core_clk);
		dtc_service_a[0] <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : dtc_a0
	task automatic tick_check(input int period, input string what);
		logic [7:0] v;
		int n;
		v = count_value_ch0;
		n = 0;
		while (count_value_ch0 === v && n < 200) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		v = count_value_ch0;
		repeat (2 * period) @(posedge core_clk);
		#1;
		check(what, count_value_ch0, v + 8'h02);
	endtask : tick_check
	task automatic final_report();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rd(OFF_CTRL_CH0, CTRL_RST, "ctrl0 reset");
		rd(OFF_CTRL_CH1, CTRL_RST, "ctrl1 reset");
		rd(OFF_STAT_CH0, STAT_CH0_RST, "stat0 reset");
		rd(OFF_STAT_CH1, STAT_CH1_RST, "stat1 reset");
		check("out after reset", {6'h00, timer_out}, 8'h00);
		check("out enable idle", {6'h00, timer_out_en}, 8'h00);
		wr(OFF_CTRL_CH0, 8'hff);
		rd(OFF_CTRL_CH0, 8'hff, "ctrl0 rw");
		wr(OFF_CTRL_CH0, 8'h00);
		wr(OFF_STAT_CH1, 8'h00);
		rd(OFF_STAT_CH1, 8'h10, "stat1 bit4 fixed");
		wr(3'h6, 8'hff);
		rd(3'h6, READ_ZERO, "unmapped");
		$display("test reset done");
	endtask : t_reset
	task automatic t_match();
		// channel 0 is never set to cascade while channel 1 is
		wr(OFF_CTRL_CH1, 8'h04);
		wr(OFF_STAT_CH0, 8'h13);
		wr(OFF_CTRL_CH0, 8'h4d);
		check("out en on", {7'h00, timer_out_en[0]}, 8'h01);
		ext_edges(0, 4);
		check("count rise", count_value_ch0, 8'h02);
		rd(OFF_STAT_CH0, 8'h13, "no flag at equality");
		ext_edges(0, 2);
		check("clear on a", count_value_ch0, 8'h00);
		check("cascade ch1", count_value_ch1, 8'h01);
		check("irq a", {7'h00, match_a_irq[0]}, 8'h01);
		check("irq b gated", {7'h00, match_b_irq[0]}, 8'h00);
		check("toggle a", {7'h00, timer_out[0]}, 8'h01);
		check("conv start", conv_cnt[7:0], 8'h01);
		wr(OFF_STAT_CH0, 8'h13);
		rd(OFF_STAT_CH0, 8'h53, "zero w/o read");
		wr(OFF_STAT_CH0, 8'hf3);
		rd(OFF_STAT_CH0, 8'h53, "one no effect");
		wr(OFF_STAT_CH0, 8'h13);
		rd(OFF_STAT_CH0, 8'h13, "read then zero");
		check("irq a cleared", {7'h00, match_a_irq[0]}, 8'h00);
		$display("test match done");
	endtask : t_match
	task automatic t_dtc();
		wr(OFF_STAT_CH0, 8'h03);
		ext_edges(0, 6);
		check("conv blocked", conv_cnt[7:0], 8'h01);
		check("toggle back", {7'h00, timer_out[0]}, 8'h00);
		dtc_a0();
		check("dtc kept", {7'h00, match_a_irq[0]}, 8'h01);
		@(posedge core_clk);
		irq_disable_select_a <= 2'h0;
		dtc_a0();
		check("dtc cleared", {7'h00, match_a_irq[0]}, 8'h00);
		rd(OFF_STAT_CH0, 8'h03, "dtc stat0");
		$display("test dtc done");
	endtask : t_dtc
	task automatic t_priority();
		@(posedge core_clk);
		cmp_a1 <= 8'h02;
		cmp_b1 <= 8'h02;
		wr(OFF_STAT_CH1, 8'h09);
		wr(OFF_CTRL_CH1, 8'h96);
		ext_edges(1, 2);
		check("high over low", {7'h00, timer_out[1]}, 8'h01);
		check("clear on b", count_value_ch1, 8'h00);
		check("irq b1", {7'h00, match_b_irq[1]}, 8'h01);
		check("irq a1 gated", {7'h00, match_a_irq[1]}, 8'h00);
		rd(OFF_STAT_CH1, 8'hd9, "both flags");
		wr(OFF_STAT_CH1, 8'h0e);
		@(posedge core_clk);
		cmp_a1 <= 8'h01;
		cmp_b1 <= 8'h01;
		ext_edges(1, 4);
		check("toggle over high", {7'h00, timer_out[1]}, 8'h00);
		$display("test priority done");
	endtask : t_priority
	task automatic t_extreset();
		@(posedge core_clk);
		cmp_a1 <= 8'hf0;
		cmp_b1 <= 8'hf0;
		wr(OFF_CTRL_CH1, 8'h1d);
		ext_edges(1, 4);
		check("ext rise ch1", count_value_ch1, 8'h02);
		@(posedge core_clk);
		ext_reset_in[1] <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		check("ext reset clear", count_value_ch1, 8'h00);
		@(posedge core_clk);
		ext_reset_in[1] <= 1'b0;
		$display("test ext reset done");
	endtask : t_extreset
	task automatic t_wrap();
		wr(OFF_CTRL_CH0, 8'h27);
		ext_edges(0, 256);
		check("wrap count", count_value_ch0, 8'h00);
		check("wrap irq", {7'h00, wrap_irq[0]}, 8'h01);
		check("irq a disabled", {7'h00, match_a_irq[0]}, 8'h00);
		check("irq b disabled", {7'h00, match_b_irq[0]}, 8'h00);
		rd(OFF_STAT_CH0, 8'he3, "wrap flags");
		// read and zero write back to back
		@(posedge core_clk);
		reg_addr <= OFF_STAT_CH0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		reg_wdata <= 8'h03;
		#1;
		rdv = reg_rdata;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
		check("b2b read", rdv, 8'he3);
		rd(OFF_STAT_CH0, 8'h03, "b2b clear");
		check("wrap irq cleared", {7'h00, wrap_irq[0]}, 8'h00);
		$display("test wrap done");
	endtask : t_wrap
	task automatic t_prescale();
		logic [7:0] v;
		wr(OFF_CTRL_CH0, 8'h01);
		tick_check(8, "div8");
		wr(OFF_CTRL_CH0, 8'h02);
		tick_check(64, "div64");
		wr(OFF_CTRL_CH0, 8'h00);
		v = count_value_ch0;
		repeat (100) @(posedge core_clk);
		#1;
		check("stopped", count_value_ch0, v);
		$display("test prescale done");
	endtask : t_prescale
	task automatic t_standby();
		wr(OFF_CTRL_CH0, 8'h01);
		@(posedge core_clk);
		hw_standby <= 1'b1;
		@(posedge core_clk);
		hw_standby <= 1'b0;
		#1;
		rd(OFF_CTRL_CH0, CTRL_RST, "standby ctrl0");
		rd(OFF_STAT_CH0, STAT_CH0_RST, "standby stat0");
		rd(OFF_STAT_CH1, STAT_CH1_RST, "standby stat1");
		check("standby out", {6'h00, timer_out}, 8'h00);
		$display("test standby done");
	endtask : t_standby

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst_n = 1'b0;
		hw_standby = 1'b0;
		reg_addr = '0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		cmp_a0 = 8'h02;
		cmp_b0 = 8'h80;
		cmp_a1 = 8'hf0;
		cmp_b1 = 8'hf0;
		ext_clk_in = 2'h0;
		ext_reset_in = 2'h0;
		dtc_service_a = 2'h0;
		dtc_service_b = 2'h0;
		irq_disable_select_a = 2'h3;
		irq_disable_select_b = 2'h3;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_match();
		t_dtc();
		t_priority();
		t_extreset();
		t_wrap();
		t_prescale();
		t_standby();
		final_report();
	end
endmodule : tb
